// [logic/synth_pkg.sv]
// shared constants and types for the synthesizer latch and power block
package synth_pkg;
  localparam int WORD_W = 24;

  // destination select codes in the two low word bits
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_REF     = 2'h1;
  localparam logic [1:0] SEL_N       = 2'h2;
  localparam logic [1:0] SEL_TEST    = 2'h3;

  // reference divider word layout
  localparam int REF_DIV_LSB    = 2;
  localparam int REF_DIV_W      = 14;
  localparam int BACKLASH_LSB   = 16;
  localparam int LOCK_PREC_BIT  = 18;
  localparam int TEST_BIT       = 19;
  localparam int BAND_CLK_LSB   = 20;

  // control word layout
  localparam int CORE_PWR_LSB   = 2;
  localparam int CNT_RESET_BIT  = 4;
  localparam int MUX_LSB        = 5;
  localparam int POLARITY_BIT   = 8;
  localparam int TRISTATE_BIT   = 9;
  localparam int GAIN_BIT       = 10;
  localparam int MUTE_BIT       = 11;
  localparam int LEVEL_LSB      = 12;
  localparam int CUR1_LSB       = 14;
  localparam int CUR2_LSB       = 17;
  localparam int SHUT_REQ_BIT   = 20;
  localparam int SHUT_SYNC_BIT  = 21;
  localparam int PRESC_LSB      = 22;

  // N divider word: gain bit shared with the control word
  localparam int N_GAIN_BIT     = 21;

  // reset values: ratio 1, all options off
  localparam logic [23:0] CTL_RESET = 24'h000000;
  localparam logic [23:0] REF_RESET = 24'h000005;
  localparam logic [23:0] N_RESET   = 24'h000002;

  // lock and synchronous power-down counts
  localparam logic [2:0] LOCK_CNT_FAST = 3'h3;
  localparam logic [2:0] LOCK_CNT_PREC = 3'h5;
  localparam logic [1:0] SYNC_EDGES    = 2'h2;

  typedef enum logic [1:0] {
    PWR_OFF  = 2'b00,
    PWR_ON   = 2'b01,
    PWR_SYNC = 2'b10,
    PWR_DOWN = 2'b11
  } pwr_e;
endpackage

// [logic/ser_word_if.sv]
// carrier for a completed serial word between shifter and latches
`timescale 1ns/100ps
`default_nettype none
interface ser_word_if;
  logic [23:0] word;
  logic        load;
  modport src (output word, output load);
  modport dst (input word, input load);
endinterface
`default_nettype wire

// [logic/serial_shifter.sv]
// 24-bit serial input register with strobe transfer
`timescale 1ns/100ps
`default_nettype none
module serial_shifter (
  input  wire logic  clk_sys,      // system clock
  input  wire logic  rst_n,        // synchronous reset, active low
  input  wire logic  ser_clk,      // serial clock pin
  input  wire logic  ser_data,     // serial data pin
  input  wire logic  latch_strobe, // transfer strobe pin
  ser_word_if.src    out           // completed word
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] clk_q;
  logic [1:0] dat_q;
  logic [2:0] stb_q;
  logic [23:0] shift_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clk_q <= 3'h0;
      dat_q <= 2'h0;
      stb_q <= 3'h0;
    end else begin
      clk_q <= {clk_q[1:0], ser_clk};
      dat_q <= {dat_q[0], ser_data};
      stb_q <= {stb_q[1:0], latch_strobe};
    end
  end

  // ****************************************
  // shift and transfer
  // ****************************************
  // R1: msb first shift
  // R16: never gated by power state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      shift_q <= 24'h000000;
    end else if (clk_q[1] && !clk_q[2]) begin
      shift_q <= {shift_q[22:0], dat_q[1]};
    end
  end

  // R2: strobe rise transfers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      out.word <= 24'h000000;
      out.load <= 1'b0;
    end else begin
      out.load <= stb_q[1] && !stb_q[2];
      if (stb_q[1] && !stb_q[2]) begin
        out.word <= shift_q;
      end
    end
  end
endmodule // serial_shifter
`default_nettype wire

// [logic/synth_latch_power_control.sv]
// configuration latches and power sequencing of the synthesizer
//
// Notes on behaviour
// R1: words shift in msb first, serial rising edge
// R2: strobe rise copies word by select bits
// R3: select 00 stores the control word
// R4: reference divider ratio 1 to 16383
// R5: lock needs five or three good cycles
// R6: host writes reference, control, then N
// R7: host waits before N after control
// R8: first control word powers up, starts settling
// R9: chip-enable off keeps band if N unchanged
// R10: programmed off keeps band if N unchanged
// R11: host rewrites all three if N changed
// R12: request bit alone powers down immediately
// R13: both bits: down on second divider edge
// R14: chip-enable low disables at once
// R15: power-down loads counters, quiets outputs
// R16: serial register works during power-down
// R17: prescaler select bits drive prescaler ratio
// R18: low and high pump current settings
// R19: two bits pick output level
// R20: mute outputs until lock when enabled
// R21: gain bit picks current setting two
// R22: tristate bit floats the charge pump
// R23: polarity bit sets detector sense
// R24: clearing request leaves programmed power-down
`timescale 1ns/100ps
`default_nettype none
module synth_latch_power_control (
  input  wire logic        clk_sys,           // system clock, 250 MHz
  input  wire logic        rst_n,             // synchronous reset, active low
  input  wire logic        ser_clk,           // serial clock pin
  input  wire logic        ser_data,          // serial data pin
  input  wire logic        latch_strobe,      // latch strobe pin
  input  wire logic        chip_enable,       // chip enable pin, low disables
  input  wire logic        ref_in,            // reference input pin
  input  wire logic        phase_ok,          // phase error under 15 ns
  output logic [1:0]       prescaler_sel,     // prescaler ratio select
  output logic [2:0]       pump_current,      // active pump current code
  output logic             pump_hiz,          // charge pump high impedance
  output logic             detector_polarity, // phase detector sense
  output logic [1:0]       output_level,      // rf output level
  output logic             rf_out_en,         // rf outputs biased on
  output logic             lock_detect,       // digital lock
  output logic             ref_buf_en,        // reference buffer enable
  output logic             counters_load,     // counters held in load state
  output logic             ref_div_tick,      // reference divider output pulse
  output logic             band_select_start, // band selection pulse
  output logic             bias_settle_start, // oscillator bias start pulse
  output logic             powered_down,      // device in power-down
  output logic [23:0]      n_word             // stored N divider word
);
  // ****************************************
  // serial input
  // ****************************************
  ser_word_if sw ();

  serial_shifter u_shift (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .ser_clk      (ser_clk),
    .ser_data     (ser_data),
    .latch_strobe (latch_strobe),
    .out          (sw.src)
  );

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] ce_q;
  logic [2:0] ref_q;
  logic [1:0] pok_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ce_q  <= 2'h0;
      ref_q <= 3'h0;
      pok_q <= 2'h0;
    end else begin
      ce_q  <= {ce_q[0], chip_enable};
      ref_q <= {ref_q[1:0], ref_in};
      pok_q <= {pok_q[0], phase_ok};
    end
  end

  logic ref_edge;
  assign ref_edge = ref_q[1] && !ref_q[2];

  // ****************************************
  // latches
  // ****************************************
  logic [23:0] ctl_q;
  logic [23:0] refw_q;
  logic [23:0] n_q;
  logic        gain_q;
  logic        ld_ctl;
  logic        ld_ref;
  logic        ld_n;

  // R2: decode destination
  // R3: select 00 is control
  assign ld_ctl = sw.load && (sw.word[1:0] == synth_pkg::SEL_CONTROL);
  assign ld_ref = sw.load && (sw.word[1:0] == synth_pkg::SEL_REF);
  assign ld_n   = sw.load && (sw.word[1:0] == synth_pkg::SEL_N);
  // test latch words are ignored on purpose: factory use only

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctl_q  <= synth_pkg::CTL_RESET;
      refw_q <= synth_pkg::REF_RESET;
      n_q    <= synth_pkg::N_RESET;
    end else begin
      if (ld_ctl) begin
        ctl_q <= sw.word;
      end
      if (ld_ref) begin
        refw_q <= sw.word;
      end
      if (ld_n) begin
        n_q <= sw.word;
      end
    end
  end

  // gain bit follows whichever word wrote it last
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gain_q <= 1'b0;
    end else if (ld_ctl) begin
      gain_q <= sw.word[synth_pkg::GAIN_BIT];
    end else if (ld_n) begin
      gain_q <= sw.word[synth_pkg::N_GAIN_BIT];
    end
  end

  // ****************************************
  // power state
  // ****************************************
  synth_pkg::pwr_e state_q;
  synth_pkg::pwr_e state_d;
  logic [1:0]      sync_cnt_q;
  logic            req_bit;
  logic            sync_bit;
  logic            active;

  assign req_bit  = sw.word[synth_pkg::SHUT_REQ_BIT];
  assign sync_bit = sw.word[synth_pkg::SHUT_SYNC_BIT];

  always_comb begin
    state_d = state_q;
    if (ld_ctl) begin
      if (!req_bit) begin
        // R8: control word powers up
        // R24: cleared request resumes
        state_d = synth_pkg::PWR_ON;
      end else if (!sync_bit || state_q != synth_pkg::PWR_ON) begin
        // R12: immediate power-down
        state_d = synth_pkg::PWR_DOWN;
      end else begin
        // R13: wait on divider edges
        state_d = synth_pkg::PWR_SYNC;
      end
    end else if (state_q == synth_pkg::PWR_SYNC && ref_div_tick &&
                 sync_cnt_q == synth_pkg::SYNC_EDGES - 2'h1) begin
      // R13: second edge after strobe
      state_d = synth_pkg::PWR_DOWN;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= synth_pkg::PWR_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_cnt_q <= 2'h0;
    end else if (state_q != synth_pkg::PWR_SYNC) begin
      sync_cnt_q <= 2'h0;
    end else if (ref_div_tick) begin
      sync_cnt_q <= sync_cnt_q + 2'h1;
    end
  end

  // R14: pin low overrides programmed bits
  assign active = ce_q[1] &&
                  (state_q == synth_pkg::PWR_ON || state_q == synth_pkg::PWR_SYNC);

  // R8: one pulse when initial off goes straight to on
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bias_settle_start <= 1'b0;
    end else begin
      bias_settle_start <= (state_q == synth_pkg::PWR_OFF) &&
                           (state_d == synth_pkg::PWR_ON);
    end
  end

  // ****************************************
  // reference divider
  // ****************************************
  logic [13:0] ratio;
  logic [13:0] rcnt_q;

  // R4: ratio 0 behaves as 1
  assign ratio = refw_q[synth_pkg::REF_DIV_LSB +: synth_pkg::REF_DIV_W];

  // R15: counter held at load while down
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rcnt_q       <= 14'h0000;
      ref_div_tick <= 1'b0;
    end else if (!active) begin
      rcnt_q       <= 14'h0000;
      ref_div_tick <= 1'b0;
    end else if (ref_edge) begin
      ref_div_tick <= (rcnt_q + 14'h0001 >= ratio);
      rcnt_q       <= (rcnt_q + 14'h0001 >= ratio) ? 14'h0000 : rcnt_q + 14'h0001;
    end else begin
      ref_div_tick <= 1'b0;
    end
  end

  // ****************************************
  // lock detection
  // ****************************************
  logic [2:0] lock_cnt_q;
  logic [2:0] lock_need;

  // R5: precision bit picks the count
  assign lock_need = refw_q[synth_pkg::LOCK_PREC_BIT] ?
                     synth_pkg::LOCK_CNT_PREC : synth_pkg::LOCK_CNT_FAST;

  // R15: lock reset during power-down
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !active) begin
      lock_cnt_q  <= 3'h0;
      lock_detect <= 1'b0;
    end else if (ref_div_tick) begin
      if (!pok_q[1]) begin
        lock_cnt_q  <= 3'h0;
        lock_detect <= 1'b0;
      end else if (lock_cnt_q + 3'h1 >= lock_need) begin
        lock_cnt_q  <= lock_need;
        lock_detect <= 1'b1;
      end else begin
        lock_cnt_q  <= lock_cnt_q + 3'h1;
      end
    end
  end

  // ****************************************
  // band selection
  // ****************************************
  // R9: band only reselected on N write
  // R10: power cycling leaves band alone
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      band_select_start <= 1'b0;
    end else begin
      band_select_start <= ld_n;
    end
  end

  // ****************************************
  // analog controls
  // ****************************************
  function automatic logic [2:0] pick_current(input logic [23:0] w, input logic g);
    // R18: two current settings
    // R21: gain picks setting two
    pick_current = g ? w[synth_pkg::CUR2_LSB +: 3] : w[synth_pkg::CUR1_LSB +: 3];
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prescaler_sel     <= 2'h0;
      pump_current      <= 3'h0;
      pump_hiz          <= 1'b1;
      detector_polarity <= 1'b0;
      output_level      <= 2'h0;
      rf_out_en         <= 1'b0;
      ref_buf_en        <= 1'b0;
      counters_load     <= 1'b1;
      powered_down      <= 1'b1;
      n_word            <= synth_pkg::N_RESET;
    end else begin
      // R17: prescaler select
      prescaler_sel     <= ctl_q[synth_pkg::PRESC_LSB +: 2];
      pump_current      <= pick_current(ctl_q, gain_q);
      // R22: tristate bit, R15: down floats pump
      pump_hiz          <= ctl_q[synth_pkg::TRISTATE_BIT] || !active;
      // R23: detector sense
      detector_polarity <= ctl_q[synth_pkg::POLARITY_BIT];
      // R19: output level
      output_level      <= ctl_q[synth_pkg::LEVEL_LSB +: 2];
      // R20: mute until lock
      // R15: outputs off while down
      rf_out_en         <= active && !(ctl_q[synth_pkg::MUTE_BIT] && !lock_detect);
      ref_buf_en        <= active;
      counters_load     <= !active;
      powered_down      <= !active;
      n_word            <= n_q;
    end
  end
endmodule // synth_latch_power_control
`default_nettype wire

// [testbench/ser_host.sv]
// host model that writes words over the three-wire serial link
`timescale 1ns/100ps
`default_nettype none
module ser_host (
  output logic ser_clk,     // serial clock, still between frames
  output logic ser_data,    // serial data
  output logic latch_strobe // transfer strobe
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    latch_strobe = 1'b0;
  end
  // msb first, one bit per rising edge
  // steps are 80 ns, a multiple of the system period, so calls made just
  // after a system edge keep every pin change off the sampling edge
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      ser_data = w[i];
      #80 ser_clk = 1'b1;
      #80 ser_clk = 1'b0;
    end
    // released data line shows the inverse, never the held bit
    ser_data = ~w[0];
    #80 latch_strobe = 1'b1;
    #80 latch_strobe = 1'b0;
  endtask
endmodule // ser_host
`default_nettype wire

// [testbench/synth_sva.sv]
// assertions on the power and latch outputs of the synthesizer block
`timescale 1ns/100ps
`default_nettype none
module synth_sva (
  input wire logic        clk_sys,           // system clock
  input wire logic        rst_n,             // synchronous reset
  input wire logic        chip_enable,       // chip enable pin
  input wire logic        powered_down,      // power-down state
  input wire logic        pump_hiz,          // pump floating
  input wire logic        counters_load,     // counters held
  input wire logic        ref_buf_en,        // reference buffer on
  input wire logic        rf_out_en,         // rf outputs on
  input wire logic        lock_detect,       // digital lock
  input wire logic        ref_div_tick,      // divider pulse
  input wire logic        band_select_start, // band pulse
  input wire logic        bias_settle_start, // bias pulse
  input wire logic [23:0] n_word             // stored N word
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_down_pump_hiz: assert property (powered_down |-> pump_hiz)
    else $error("pump driven while powered down");
  a_down_counters: assert property (powered_down |-> counters_load && !ref_buf_en)
    else $error("counters or buffer active while down");
  a_down_rf_off: assert property (powered_down |-> !rf_out_en)
    else $error("rf on while powered down");
  a_down_lock_clr: assert property (powered_down [*3] |-> !lock_detect)
    else $error("lock held while powered down");
  a_ce_disables: assert property (!chip_enable [*5] |=> powered_down)
    else $error("chip enable low did not power down");
  a_held_no_tick: assert property (counters_load [*3] |-> !ref_div_tick)
    else $error("divider ticks while held in load");
  a_band_after_n: assert property (!$stable(n_word) |-> $past(band_select_start))
    else $error("N word stored without band pulse");
  a_band_pulse: assert property (band_select_start |=> !band_select_start)
    else $error("band pulse longer than a cycle");
  a_bias_powers: assert property (bias_settle_start |-> ##[0:2] !powered_down)
    else $error("bias start without power-up");
endmodule // synth_sva
`default_nettype wire

// [testbench/synth_latch_power_control_tb.sv]
// self-checking bench for the synthesizer latch and power block
`timescale 1ns/100ps
`default_nettype none
module synth_latch_power_control_tb;
  localparam logic [23:0] CTL_A = 24'h8AD100;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        chip_enable = 1'b1;
  logic        ref_in = 1'b0;
  logic        phase_ok = 1'b0;
  wire logic   ser_clk, ser_data, latch_strobe;
  logic [1:0]  prescaler_sel, output_level;
  logic [2:0]  pump_current;
  logic        pump_hiz, detector_polarity, rf_out_en, lock_detect, ref_buf_en;
  logic        counters_load, ref_div_tick, band_select_start, bias_settle_start;
  logic        powered_down;
  logic [23:0] n_word;
  int          mismatches = 0, n_checks = 0, ticks = 0, t0 = 0, n_band = 0, n_bias = 0;

  always #2 clk_sys = ~clk_sys;
  always #32 ref_in = ~ref_in;

  synth_latch_power_control synth_latch_power_control_i (.clk_sys, .rst_n, .ser_clk,
    .ser_data, .latch_strobe, .chip_enable, .ref_in, .phase_ok, .prescaler_sel,
    .pump_current, .pump_hiz, .detector_polarity, .output_level, .rf_out_en, .lock_detect,
    .ref_buf_en, .counters_load, .ref_div_tick, .band_select_start, .bias_settle_start,
    .powered_down, .n_word);
  ser_host ser_host_i (.ser_clk, .ser_data, .latch_strobe);

  always @(posedge clk_sys) begin
    ticks += int'(ref_div_tick);
    n_band += int'(band_select_start);
    n_bias += int'(bias_settle_start);
  end
  // sample the tick count just after the synced strobe has moved the word into the latch
  always @(posedge latch_strobe) #16 t0 = ticks;

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [23:0] w);
    ser_host_i.send(w);
    cyc(2);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    chk(24'(powered_down), 24'h1);
    chk(24'(pump_hiz), 24'h1);
    chk(n_word, synth_pkg::N_RESET);
    $display("reset test done");
  endtask
  task automatic t_program;
    wr(24'h000009);
    wr(CTL_A);
    chk(24'(n_bias), 24'h1);
    chk(24'(powered_down), 24'h0);
    chk(24'(prescaler_sel), 24'h2);
    chk(24'(pump_current), 24'h3);
    chk(24'(output_level), 24'h1);
    chk(24'(detector_polarity), 24'h1);
    chk(24'(pump_hiz), 24'h0);
    // settling gap, shortened: the model has no analog bias to settle
    cyc(500);
    wr(24'h012342);
    chk(n_word, 24'h012342);
    chk(24'(n_band), 24'h1);
    wr(CTL_A | 24'h000600);
    chk(24'(pump_current), 24'h5);
    chk(24'(pump_hiz), 24'h1);
    wr(24'hFFFFFF);
    chk(24'(prescaler_sel), 24'h2);
    chk(n_word, 24'h012342);
    $display("program test done");
  endtask
  task automatic t_lock;
    int n;
    logic early;
    for (int p = 0; p < 2; p++) begin
      phase_ok = 1'b0;
      wr(24'h000009 | (24'(p) << 18));
      wr(CTL_A | 24'h000800);
      cyc(80);
      for (n = 0; n < 100 && ref_div_tick !== 1'b1; n++) cyc(1);
      phase_ok = 1'b1;
      n = 0;
      early = 1'b0;
      cyc(1);
      for (int k = 0; k < 400 && lock_detect !== 1'b1; k++) begin
        n += int'(ref_div_tick);
        early |= rf_out_en;
        cyc(1);
      end
      chk(24'(n), 24'(3 + 2 * p));
      chk(24'(early), 24'h0);
      cyc(2);
      chk(24'(rf_out_en), 24'h1);
    end
    $display("lock test done");
  endtask
  task automatic t_async;
    int nb;
    wr(CTL_A | 24'h100000);
    chk(24'(powered_down), 24'h1);
    chk(24'({pump_hiz, counters_load, ref_buf_en, rf_out_en, lock_detect}), 24'h18);
    wr(CTL_A | 24'h102000);
    chk(24'(output_level), 24'h3);
    chk(24'(powered_down), 24'h1);
    wr(24'h012342);
    chk(n_word, 24'h012342);
    nb = n_band;
    wr(CTL_A);
    chk(24'(powered_down), 24'h0);
    chk(24'(counters_load), 24'h0);
    chk(24'(n_band - nb), 24'h0);
    $display("async test done");
  endtask
  task automatic t_sync;
    int n;
    wr(CTL_A | 24'h300000);
    for (n = 0; n < 200 && powered_down !== 1'b1; n++) cyc(1);
    chk(24'(powered_down), 24'h1);
    chk(24'(ticks - t0), 24'h2);
    wr(CTL_A);
    $display("sync test done");
  endtask
  task automatic t_ce;
    int nb;
    nb = n_band;
    chip_enable = 1'b0;
    cyc(6);
    chk(24'(powered_down), 24'h1);
    chip_enable = 1'b1;
    cyc(6);
    chk(24'(powered_down), 24'h0);
    chk(24'(n_band - nb), 24'h0);
    $display("chip enable test done");
  endtask

  initial begin
    cyc(5);
    rst_n = 1'b1;
    cyc(2);
    t_reset;
    t_program;
    t_lock;
    t_async;
    t_sync;
    t_ce;
    summarize;
  end
  // watchdog: the tests need well under a third of this span
  initial begin
    #300000;
    mismatches++;
    summarize;
  end
endmodule // synth_latch_power_control_tb

bind synth_latch_power_control synth_sva synth_sva_i (.clk_sys, .rst_n, .chip_enable,
  .powered_down, .pump_hiz, .counters_load, .ref_buf_en, .rf_out_en, .lock_detect,
  .ref_div_tick, .band_select_start, .bias_settle_start, .n_word);
`default_nettype wire
